// ---- hw/acfs_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - read count shows readable words, never more than truly present, log2(depth)+1 wide
// - a read at an edge shows in the read count right after that same edge
// - occupancy count gives words currently held, log2(depth)+1 bits wide
// - upper flag high when stored words reach or pass upper threshold
// - upper flag low when stored words fall below upper threshold
// - lower flag high when stored words are at or below lower threshold
// - lower flag low when stored words exceed lower threshold
// - address channel fields are packed into one stored entry per transfer
// - 8-bit burst length accompanies each address and is stored with it
// - 3-bit burst size accompanies each address and is stored with it
module acfs_top
(
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic [acfs_pkg::THR_W-1:0]    upperThr,
  input  wire logic [acfs_pkg::THR_W-1:0]    lowerThr,
  input  wire logic [acfs_pkg::ID_W-1:0]     sArId,
  input  wire logic [acfs_pkg::ADDR_W-1:0]   sArAddr,
  input  wire logic [acfs_pkg::LEN_W-1:0]    sArLen,
  input  wire logic [acfs_pkg::SIZE_W-1:0]   sArSize,
  input  wire logic                          sArValid,
  output logic                               sArReady,
  output logic [acfs_pkg::ID_W-1:0]          mArId,
  output logic [acfs_pkg::ADDR_W-1:0]        mArAddr,
  output logic [acfs_pkg::LEN_W-1:0]         mArLen,
  output logic [acfs_pkg::SIZE_W-1:0]        mArSize,
  output logic                               mArValid,
  input  wire logic                          mArReady,
  output logic [acfs_pkg::CNT_W-1:0]         rdDataCount,
  output logic [acfs_pkg::CNT_W-1:0]         dataCount,
  output logic                               upperFlag,
  output logic                               lowerFlag,
  input  wire logic [acfs_pkg::RA_W-1:0]     regAddr,
  input  wire logic [acfs_pkg::RD_W-1:0]     regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [acfs_pkg::RD_W-1:0]          regRdata,
  output logic                               irq
);
  import acfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage and pointers

  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]   wrPtr;
  logic [PTR_W-1:0]   rdPtr;
  logic [CNT_W-1:0]   memCount;
  logic [CNT_W-1:0]   next_memCount;
  logic [CNT_W-1:0]   next_total;
  logic [THR_W-1:0]   upperHeld;
  logic [THR_W-1:0]   lowerHeld;
  logic               acceptEn;
  logic [NEV-1:0]     status;
  logic [NEV-1:0]     irqEn;
  logic [NEV-1:0]     clrHit;
  logic [NEV-1:0]     event_;
  logic               next_upper;
  logic               next_lower;
  logic [ENTRY_W-1:0] inEntry;
  logic [ENTRY_W-1:0] headEntry;
  logic               push;
  logic               pop;
  logic               load;
  logic               outTake;

  ////////////////////////////////////////////////////////////////////////////
  // handshake terms

  // id, address, length and size travel as one word per accepted transfer
  assign inEntry = {sArId, sArAddr, sArLen, sArSize};

  // entry taken only on valid and ready together
  assign push = sArValid & sArReady;

  // master keeps fields stable while waiting, so sampling at push is safe
  assign outTake = mArValid & mArReady;

  // refill the output stage when it is empty or being drained
  assign load = (memCount != '0) & (~mArValid | mArReady);
  assign pop  = load;

  assign headEntry = mem[rdPtr];

  always_comb
  begin
    next_memCount = memCount;
    if (push && !pop)
    begin
      next_memCount = memCount + CNT_W'(1);
    end
    else if (pop && !push)
    begin
      next_memCount = memCount - CNT_W'(1);
    end
  end

  // total held counts the output stage as well as the array
  always_comb
  begin
    next_total = dataCount;
    if (push && !outTake)
    begin
      next_total = dataCount + CNT_W'(1);
    end
    else if (outTake && !push)
    begin
      next_total = dataCount - CNT_W'(1);
    end
  end

  assign next_upper = (next_total >= CNT_W'(upperHeld));
  assign next_lower = (next_total <= CNT_W'(lowerHeld));

  ////////////////////////////////////////////////////////////////////////////
  // thresholds

  // sampled while reset is held so a live change during reset is picked up
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      upperHeld <= upperThr;
      lowerHeld <= lowerThr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write side

  always_ff @(posedge sys_clk)
  begin
    if (ce && push)
    begin
      mem[wrPtr] <= inEntry;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
    end
    else if (ce && push)
    begin
      wrPtr <= wrPtr + PTR_W'(1);
    end
  end

  // ready is dropped as soon as the total would reach the depth
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sArReady <= 1'b0;
    end
    else if (ce)
    begin
      sArReady <= acceptEn & (next_total < CNT_W'(DEPTH));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdPtr    <= '0;
      memCount <= '0;
    end
    else if (ce)
    begin
      memCount <= next_memCount;
      if (pop)
      begin
        rdPtr <= rdPtr + PTR_W'(1);
      end
    end
  end

  // fields leave exactly as they were stored
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mArValid <= 1'b0;
      mArId    <= '0;
      mArAddr  <= '0;
      mArLen   <= '0;
      mArSize  <= '0;
    end
    else if (ce)
    begin
      if (load)
      begin
        mArValid <= 1'b1;
        mArId    <= headEntry[ID_LSB +: ID_W];
        mArAddr  <= headEntry[ADDR_LSB +: ADDR_W];
        mArLen   <= headEntry[LEN_LSB +: LEN_W];
        mArSize  <= headEntry[SIZE_LSB +: SIZE_W];
      end
      else if (outTake)
      begin
        mArValid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counts and level flags

  // registered from the next state: a drain is visible right after the same edge that takes it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dataCount   <= '0;
      rdDataCount <= '0;
    end
    else if (ce)
    begin
      dataCount <= next_total;
      // the output stage is only counted once it is really loaded
      rdDataCount <= next_memCount + CNT_W'(load | (mArValid & ~mArReady));
    end
  end

  // lower flag starts high since the store is empty after reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      upperFlag <= 1'b0;
      lowerFlag <= 1'b1;
    end
    else if (ce)
    begin
      upperFlag <= next_upper;
      lowerFlag <= next_lower;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acceptEn <= CTRL_RST[0];
      irqEn    <= IEN_RST;
    end
    else if (ce && regWr)
    begin
      if (regAddr == OFS_CTRL)
      begin
        acceptEn <= regWdata[0];
      end
      else if (regAddr == OFS_IEN)
      begin
        irqEn <= regWdata[NEV-1:0];
      end
    end
  end

  assign clrHit = (regWr && regAddr == OFS_ICLR) ? regWdata[NEV-1:0] : '0;

  // read data stands for exactly one cycle; unmapped offsets read zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      regRdata <= '0;
    end
    else if (ce)
    begin
      regRdata <= '0;
      if (regRd)
      begin
        if (regAddr == OFS_CTRL)
        begin
          regRdata <= {31'h0000_0000, acceptEn};
        end
        else if (regAddr == OFS_LEVEL)
        begin
          regRdata[LVL_DC_LSB +: CNT_W]  <= dataCount;
          regRdata[LVL_RDC_LSB +: CNT_W] <= rdDataCount;
          regRdata[LVL_UP_BIT]           <= upperFlag;
          regRdata[LVL_LO_BIT]           <= lowerFlag;
        end
        else if (regAddr == OFS_STAT)
        begin
          regRdata[NEV-1:0] <= status;
        end
        else if (regAddr == OFS_IEN)
        begin
          regRdata[NEV-1:0] <= irqEn;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign event_[EV_UPPER]  = next_upper & ~upperFlag;
  assign event_[EV_LOWER]  = next_lower & ~lowerFlag;
  assign event_[EV_REFUSE] = sArValid & ~sArReady & (dataCount == CNT_W'(DEPTH));

  // a new event in the clearing cycle survives the clear
  for (genvar i = 0; i < NEV; i++)
  begin : g_stat
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        status[i] <= 1'b0;
      end
      else if (ce)
      begin
        status[i] <= event_[i] | (status[i] & ~clrHit[i]);
      end
    end
  end

  // one cycle behind the status bits, traded for a flop-driven output
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else if (ce)
    begin
      irq <= |(status & irqEn);
    end
  end

endmodule : acfs_top

// ---- hw/acfs_pkg.sv ----
package acfs_pkg;
  // storage geometry
  localparam int DEPTH   = 16;
  localparam int PTR_W   = 4;
  localparam int CNT_W   = 5;
  localparam int THR_W   = 4;
  // read address fields
  localparam int ID_W    = 4;
  localparam int ADDR_W  = 32;
  localparam int LEN_W   = 8;
  localparam int SIZE_W  = 3;
  localparam int ENTRY_W = ID_W + ADDR_W + LEN_W + SIZE_W;
  // field positions inside one stored entry
  localparam int SIZE_LSB = 0;
  localparam int LEN_LSB  = 3;
  localparam int ADDR_LSB = 11;
  localparam int ID_LSB   = 43;
  // register port
  localparam int RA_W = 8;
  localparam int RD_W = 32;
  localparam logic [RA_W-1:0] OFS_CTRL  = 8'h00;
  localparam logic [RA_W-1:0] OFS_LEVEL = 8'h04;
  localparam logic [RA_W-1:0] OFS_STAT  = 8'h08;
  localparam logic [RA_W-1:0] OFS_IEN   = 8'h0C;
  localparam logic [RA_W-1:0] OFS_ICLR  = 8'h10;
  localparam logic [RD_W-1:0] CTRL_RST  = 32'h0000_0001;
  // interrupt events: 0 upper flag rose, 1 lower flag rose, 2 entry refused while full
  localparam int NEV = 3;
  localparam int EV_UPPER  = 0;
  localparam int EV_LOWER  = 1;
  localparam int EV_REFUSE = 2;
  localparam logic [NEV-1:0] IEN_RST = 3'h0;
  // level register field positions
  localparam int LVL_DC_LSB  = 0;
  localparam int LVL_RDC_LSB = 8;
  localparam int LVL_UP_BIT  = 16;
  localparam int LVL_LO_BIT  = 17;
endpackage : acfs_pkg

// ---- dv/acfs_sva.sv ----
`timescale 1ns/1ps
module acfs_sva
(
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic                        ce,
  input wire logic [acfs_pkg::THR_W-1:0]  upperThr,
  input wire logic [acfs_pkg::THR_W-1:0]  lowerThr,
  input wire logic                        sArValid,
  input wire logic                        sArReady,
  input wire logic                        mArValid,
  input wire logic                        mArReady,
  input wire logic [acfs_pkg::ADDR_W-1:0] mArAddr,
  input wire logic [acfs_pkg::CNT_W-1:0]  rdDataCount,
  input wire logic [acfs_pkg::CNT_W-1:0]  dataCount,
  input wire logic                        upperFlag,
  input wire logic                        lowerFlag
);
  import acfs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // flags are registered with the count in the same cycle; they are judged only on a steady count after reset
  logic             prevRst;
  logic [CNT_W-1:0] prevCnt;
  logic             steady;
  always_ff @(posedge sys_clk)
  begin
    prevRst <= rst_n;
    prevCnt <= dataCount;
  end
  assign steady = prevRst && prevCnt == dataCount;
  sequence sPush;
    ce && sArValid && sArReady && !(mArValid && mArReady);
  endsequence
  sequence sPop;
    ce && mArValid && mArReady && !(sArValid && sArReady);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_full: assert property (dataCount == DEPTH |-> !sArReady)
    else $error("ready while full");
  chk_count_inc: assert property (sPush |=> dataCount == $past(dataCount) + 5'h01)
    else $error("count missed a push");
  chk_count_dec: assert property (sPop |=> dataCount == $past(dataCount) - 5'h01)
    else $error("count missed a pop");
  chk_read_bound: assert property (rdDataCount <= dataCount)
    else $error("read count above held count");
  chk_head_count: assert property (mArValid |-> rdDataCount != 5'h00)
    else $error("head not counted");
  chk_fields_hold: assert property (mArValid && !mArReady |=> mArValid && $stable(mArAddr))
    else $error("head changed before taken");
  chk_upper_set: assert property (steady && dataCount >= upperThr |-> upperFlag)
    else $error("upper flag low");
  chk_upper_clr: assert property (steady && dataCount < upperThr |-> !upperFlag)
    else $error("upper flag high");
  chk_lower_set: assert property (steady && dataCount <= lowerThr |-> lowerFlag)
    else $error("lower flag low");
  chk_lower_clr: assert property (steady && dataCount > lowerThr |-> !lowerFlag)
    else $error("lower flag high");
endmodule : acfs_sva
bind acfs_top acfs_sva u_sva (.sys_clk, .rst_n, .ce, .upperThr, .lowerThr, .sArValid,
  .sArReady, .mArValid, .mArReady, .mArAddr, .rdDataCount, .dataCount, .upperFlag, .lowerFlag);

// ---- dv/acfs_slave_model.sv ----
`timescale 1ns/1ps
module acfs_slave_model
(
  input  wire logic       sys_clk,
  input  wire logic [1:0] mode,
  output logic            mArReady
);
  // mode 0 stalls at random, 1 always takes, 2 never takes
  initial mArReady = 1'b0;
  always @(posedge sys_clk)
    mArReady <= mode == 2'h1 || (mode == 2'h0 && $urandom_range(1) != 0);
endmodule : acfs_slave_model

// ---- dv/acfs_top_tb.sv ----
`timescale 1ns/1ps
module acfs_top_tb;
  import acfs_pkg::*;
  logic               sys_clk, rst_n, ce, sArValid, regWr, regRd;
  logic               sArReady, mArValid, mArReady, upperFlag, lowerFlag, irq;
  logic [THR_W-1:0]   upperThr, lowerThr, u, l;
  logic [ID_W-1:0]    sArId, mArId;
  logic [ADDR_W-1:0]  sArAddr, mArAddr;
  logic [LEN_W-1:0]   sArLen, mArLen;
  logic [SIZE_W-1:0]  sArSize, mArSize;
  logic [CNT_W-1:0]   rdDataCount, dataCount;
  logic [RA_W-1:0]    regAddr;
  logic [RD_W-1:0]    regWdata, regRdata, rv;
  logic [1:0]         mode;
  logic [ENTRY_W-1:0] expq[$];
  int                 mismatches, tests_run;
  acfs_top uut (.sys_clk, .rst_n, .ce, .upperThr, .lowerThr, .sArId, .sArAddr, .sArLen,
    .sArSize, .sArValid, .sArReady, .mArId, .mArAddr, .mArLen, .mArSize, .mArValid,
    .mArReady, .rdDataCount, .dataCount, .upperFlag, .lowerFlag, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .irq);
  acfs_slave_model u_slv (.sys_clk, .mode, .mArReady);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  function automatic logic [RD_W-1:0] lvl(input int k);
    return {14'h0, k <= l, k >= u, 3'h0, CNT_W'(k), 3'h0, CNT_W'(k)};
  endfunction : lvl
  task automatic regW(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : regW
  task automatic regR(input logic [RA_W-1:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    rv = regRdata;
  endtask : regR
  // thresholds wander while reset is held; only the last value may count
  task automatic doReset;
    rst_n <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      // final value must be in place an edge before release to be latched
      upperThr <= i >= 6 ? u : THR_W'($urandom);
      lowerThr <= i >= 6 ? l : THR_W'($urandom);
    end
    rst_n <= 1'b1;
    expq.delete();
    @(posedge sys_clk);
  endtask : doReset
  task automatic push(input logic [ENTRY_W-1:0] e);
    int n;
    n = 0;
    {sArId, sArAddr, sArLen, sArSize} <= e;
    sArValid <= 1'b1;
    do @(posedge sys_clk); while (sArReady !== 1'b1 && n++ < 40);
    expq.push_back(e);
  endtask : push
  task automatic drop;
    sArValid <= 1'b0;
    {sArId, sArAddr, sArLen, sArSize} <= ~{sArId, sArAddr, sArLen, sArSize};
    @(posedge sys_clk);
  endtask : drop
  task automatic drain;
    mode <= 2'h0;
    for (int n = 0; n < 400 && dataCount !== 5'h00; n++) @(posedge sys_clk);
    @(posedge sys_clk);
    check("ports", {lowerFlag, upperFlag, 3'h0, rdDataCount, 3'h0, dataCount}, lvl(0));
    check("left", expq.size(), 0);
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
    if (rst_n && ce === 1'b1 && mArValid === 1'b1 && mArReady === 1'b1)
    begin
      if (expq.size() == 0)
        check("spare", 1, 0);
      else
        check("entry", {mArId, mArAddr, mArLen, mArSize}, expq.pop_front());
    end
  initial
  begin
    #(20 * 30000);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {rst_n, ce, sArValid, regWr, regRd} = 5'b01000;
    {upperThr, lowerThr, sArId, sArAddr, sArLen, sArSize, regAddr, regWdata} = '0;
    {u, l, mode, mismatches, tests_run} = '0;
    mode = 2'h2;
    void'($urandom(29688));
    for (int r = 0; r < 2; r++)
    begin
      u = r ? 4'hF : THR_W'($urandom_range(14, 8));
      l = r ? 4'h0 : THR_W'($urandom_range(7, 1));
      doReset;
      regR(OFS_CTRL);
      check("ctrl", rv, CTRL_RST);
      regR(OFS_IEN);
      check("ien", rv, IEN_RST);
      regR(8'h14);
      check("unmapped", rv, 0);
      regW(OFS_IEN, 32'h0000_0007);
      mode <= 2'h2;
      for (int k = 1; k <= DEPTH; k++)
      begin
        push(ENTRY_W'({$urandom, $urandom}));
        drop;
        regR(OFS_LEVEL);
        check("level", rv, lvl(k));
        check("ports", {lowerFlag, upperFlag, 3'h0, rdDataCount, 3'h0, dataCount}, lvl(k));
      end
      // enable low: a willing slave must not drain the frozen store
      ce <= 1'b0;
      mode <= 2'h1;
      repeat (4) @(posedge sys_clk);
      check("frozen", {mArValid, dataCount}, {1'b1, 5'h10});
      mode <= 2'h2;
      @(posedge sys_clk);
      ce <= 1'b1;
      sArValid <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check("refused", {sArReady, dataCount}, {1'b0, 5'h10});
      drop;
      drain;
      regR(OFS_STAT);
      check("status", rv, 32'h0000_0007);
      check("irq", irq, 1'b1);
      regW(OFS_IEN, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      check("masked", irq, 1'b0);
      regW(OFS_ICLR, 32'h0000_0007);
      regR(OFS_STAT);
      check("cleared", rv, 0);
      for (int i = 0; i < 40; i++)
      begin
        mode <= 2'($urandom_range(1));
        push(ENTRY_W'({$urandom, $urandom}));
        if ($urandom_range(1) != 0)
          drop;
      end
      drop;
      drain;
    end
    tally_and_finish;
  end
endmodule : acfs_top_tb
